// [hdl/strobe_xfer.sv]
// read strobe preamble detect, polarity select and domain transfer
// assumes strobe, its driven flag, data and edge clock come from pins
module strobe_xfer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // memory side pins
  input wire logic strobe_in,
  input wire logic strobe_driven,
  input wire logic [strobe_xfer_pkg::DATA_W-1:0] data_in,
  input wire logic edge_clock_one,
  // group configuration: 0 side edge, 1 top/bottom edge
  input wire logic top_bottom,
  // user stream
  output logic out_valid,
  input wire logic out_ready,
  output strobe_xfer_pkg::ddr_word_t out_data,
  // status
  output logic capture_polarity,
  output logic read_active,
  output logic overflow,
  output logic strobe_transfer_delay,
  output logic [4:0] group_size
);
  logic [2:0] s_sync1_reg, s_sync2_reg, s_prev_reg;
  logic [strobe_xfer_pkg::DATA_W-1:0] d_sync1_reg, d_sync2_reg;
  // second data stage on the falling clock edge, picked when polarity is 1
  logic [strobe_xfer_pkg::DATA_W-1:0] d_neg_reg;
  // driven flag as seen half a cycle before the rising edge
  logic drv_neg_reg;
  logic [strobe_xfer_pkg::DATA_W-1:0] rise_reg, fall_reg;
  logic e_sync1_reg, e_sync2_reg, e_prev_reg, shift_reg;
  logic pol_reg, pol_next, ovf_reg;
  logic [2:0] cnt_reg, cnt_next;
  strobe_xfer_pkg::rd_state_t st_reg, st_next;
  strobe_xfer_pkg::ddr_word_t buf_reg [2];
  logic [1:0] fill_reg;
  logic wr_ptr_reg, rd_ptr_reg;

  // one helper for both strobe edges, so the two decodes cannot drift apart
  function automatic logic edge_seen(input logic cur, input logic prev,
                                     input logic up);
    edge_seen = up ? (cur & ~prev) : (~cur & prev);
  endfunction

  // falling clock edge stages: phase sense and alternate data capture
  always_ff @(negedge clk or posedge rst)
    if (rst)
    begin
      drv_neg_reg <= 1'b0;
      d_neg_reg <= '0;
    end
    else
    begin
      drv_neg_reg <= strobe_driven;
      d_neg_reg <= d_sync1_reg;
    end

  // bit0 strobe, bit1 driven, bit2 driven flag from the falling clock edge
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      s_sync1_reg <= 3'h0;
      s_sync2_reg <= 3'h0;
      s_prev_reg <= 3'h0;
      d_sync1_reg <= '0;
      d_sync2_reg <= '0;
    end
    else
    begin
      s_sync1_reg <= {drv_neg_reg, strobe_driven, strobe_in};
      s_sync2_reg <= s_sync1_reg;
      s_prev_reg <= s_sync2_reg;
      d_sync1_reg <= data_in;
      d_sync2_reg <= d_sync1_reg;
    end

  wire strobe_s = s_sync2_reg[0];
  wire driven_s = s_sync2_reg[1];
  wire driven_p = s_prev_reg[1];
  // idle (undriven) to driven low marks the preamble
  wire preamble_seen = driven_s & ~driven_p & ~strobe_s;
  wire rise_edge = edge_seen(strobe_s, s_prev_reg[0], 1'b1);
  wire fall_edge = edge_seen(strobe_s, s_prev_reg[0], 1'b0);
  wire quiet = ~driven_s;

  always_comb
  begin
    st_next = st_reg;
    pol_next = pol_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      strobe_xfer_pkg::IDLE:
        if (preamble_seen)
        begin
          st_next = strobe_xfer_pkg::PREAMBLE;
          // driven flag not yet seen half a cycle early: late arrival, other edge
          pol_next = ~s_sync2_reg[2];
        end
      strobe_xfer_pkg::PREAMBLE:
        if (rise_edge)
          st_next = strobe_xfer_pkg::BURST;
        else if (quiet)
          st_next = strobe_xfer_pkg::IDLE;
      default:
        if (quiet)
        begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == strobe_xfer_pkg::BURST_END_CNT)
          begin
            st_next = strobe_xfer_pkg::IDLE;
            cnt_next = strobe_xfer_pkg::CNT_RST;
          end
        end
        else
          cnt_next = strobe_xfer_pkg::CNT_RST;
    endcase
  end

  // polarity only moves in idle, never mid burst
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      st_reg <= strobe_xfer_pkg::IDLE;
      pol_reg <= strobe_xfer_pkg::POL_RST;
      cnt_reg <= strobe_xfer_pkg::CNT_RST;
    end
    else
    begin
      st_reg <= st_next;
      pol_reg <= pol_next;
      cnt_reg <= cnt_next;
    end

  // chosen polarity picks the clock edge of the second data stage;
  // rise and fall halves keep their strobe edges whatever the polarity
  wire [strobe_xfer_pkg::DATA_W-1:0] cap_data =
    pol_reg ? d_neg_reg : d_sync2_reg;
  wire in_read = (st_reg != strobe_xfer_pkg::IDLE);
  wire in_burst = (st_reg == strobe_xfer_pkg::BURST);
  // the first rising edge also ends the preamble, so load it there too
  wire load_rise = in_read & rise_edge;
  wire push = in_burst & fall_edge;
  wire buf_full = (fill_reg == 2'h2);
  wire pop = out_valid & out_ready;
  // a pop in the same cycle frees the slot that a push into full needs
  wire accept = push & (~buf_full | pop);

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rise_reg <= '0;
      fall_reg <= '0;
    end
    else
    begin
      if (load_rise)
        rise_reg <= cap_data;
      if (push)
        fall_reg <= cap_data;
    end

  // two entries absorb a receiver stall; a push into a full buffer with no pop in that cycle is lost
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      fill_reg <= 2'h0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      ovf_reg <= 1'b0;
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
    end
    else
    begin
      if (accept)
      begin
        buf_reg[wr_ptr_reg] <= '{rise: rise_reg, fall: cap_data};
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      fill_reg <= fill_reg + 2'(accept ? 1 : 0)
        - 2'(pop ? 1 : 0);
      if (push & buf_full & ~pop)
        ovf_reg <= 1'b1;
    end

  // four clk cycle delay of edge clock one, rebuilt from its sampled level
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      e_sync1_reg <= 1'b0;
      e_sync2_reg <= 1'b0;
      e_prev_reg <= 1'b0;
      shift_reg <= 1'b0;
    end
    else
    begin
      e_sync1_reg <= edge_clock_one;
      e_sync2_reg <= e_sync1_reg;
      e_prev_reg <= e_sync2_reg;
      shift_reg <= e_prev_reg;
    end

  assign out_valid = (fill_reg != 2'h0);
  assign out_data = buf_reg[rd_ptr_reg];
  assign capture_polarity = pol_reg;
  assign read_active = (st_reg != strobe_xfer_pkg::IDLE);
  assign overflow = ovf_reg;
  assign strobe_transfer_delay = shift_reg;
  assign group_size = top_bottom ? 5'(strobe_xfer_pkg::GROUP_TOPBOT)
                                 : 5'(strobe_xfer_pkg::GROUP_SIDE);
endmodule

// [hdl/strobe_xfer_pkg.sv]
// constants and carriers for the read strobe polarity and transfer block
// assumes one 100 MHz system clock; strobe and data arrive from pins
// Functional notes
// - read data enters system domain through registers on a selected edge
// - polarity is chosen afresh at the start of every read
// - a detector sees strobe go from idle to driven-low preamble
// - detector output sets capture polarity for the following read
// - transfer delay shifts edge clock one by a quarter period; the code delays it by four clk cycles
// - read data is captured by the group strobe
// - one strobe cell per 16 side cells or 18 top/bottom cells
package strobe_xfer_pkg;
  localparam int GROUP_SIDE = 16;
  localparam int GROUP_TOPBOT = 18;
  localparam int DATA_W = GROUP_SIDE;
  localparam int SYS_CLK_MHZ = 100;
  localparam int SHIFT_PERCENT = 90;
  // quiet strobe time in ns that sets the burst close count
  localparam int BURST_END_NS = 40;
  localparam int BURST_END_CYC = (BURST_END_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [2:0] BURST_END_CNT = 3'(BURST_END_CYC);
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic POL_RST = 1'b0;
  typedef enum logic [1:0] {IDLE, PREAMBLE, BURST} rd_state_t;
  typedef struct packed {
    logic [DATA_W-1:0] rise;
    logic [DATA_W-1:0] fall;
  } ddr_word_t;
endpackage

// [testbench/strobe_xfer_chk.sv]
// assertions on strobe_xfer ports
// assumes a single clock domain
module strobe_xfer_chk (
  // all design ports except data_in
  input wire logic clk, rst, strobe_in, strobe_driven, edge_clock_one,
  input wire logic top_bottom, out_valid, out_ready, capture_polarity,
  input wire logic read_active, overflow, strobe_transfer_delay,
  input wire strobe_xfer_pkg::ddr_word_t out_data,
  input wire logic [4:0] group_size
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence pre_s;
    $rose(strobe_driven) && !strobe_in && !read_active;
  endsequence
  chk_pre_detect: assert property
    (pre_s |-> ##[1:5] read_active) else $error("no read");
  chk_pol_start: assert property
    ($changed(capture_polarity) |-> $rose(read_active)) else $error("pol");
  chk_pol_hold: assert property
    (read_active [*2] |-> $stable(capture_polarity)) else $error("hold");
  chk_xfer_delay: assert property
    ($rose(edge_clock_one) |-> ##[2:5] $rose(strobe_transfer_delay))
    else $error("delay");
  chk_group_size: assert property
    (group_size == (top_bottom ? 5'h12 : 5'h10)) else $error("size");
  chk_valid_cause: assert property
    ($rose(out_valid) |-> $past(read_active)) else $error("valid");
  chk_stall_hold: assert property
    (out_valid && !out_ready |=> $stable(out_data)) else $error("stall");
  chk_loss_flag: assert property
    ($rose(overflow) |-> $past(out_valid)) else $error("loss");
endmodule
bind strobe_xfer strobe_xfer_chk strobe_xfer_chk_inst (.*);

// [testbench/ddr_mem_model.sv]
// memory model driving strobe, drive flag and data
// assumes burst is called just after a falling clk edge
module ddr_mem_model (
  // clock and pins
  input wire logic clk,
  output logic strobe_in, strobe_driven,
  output logic [strobe_xfer_pkg::DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // released strobe rests high on its termination
  initial {strobe_driven, strobe_in, data_in} = 18'h10000;
  task automatic burst(strobe_xfer_pkg::ddr_word_t w[$], int h);
    strobe_driven = 1'h1;
    for (int i = -1; i < 2 * w.size(); i++)
    begin
      strobe_in = i >= 0 && !i[0];
      if (i >= 0) data_in = i[0] ? w[i/2].fall : w[i/2].rise;
      repeat (h) @(negedge clk);
    end
    {strobe_driven, strobe_in, data_in} = {2'h1, ~data_in};
  endtask
endmodule

// [testbench/strobe_xfer_test.sv]
// strobe_xfer bench
// assumes 100 MHz clk; inputs other than edge_clock_one change at falling edges
module strobe_xfer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, edge_clock_one = 1'h0, top_bottom = 1'h0;
  logic out_ready = 1'h1, strobe_in, strobe_driven, out_valid, overflow;
  logic capture_polarity, read_active, strobe_transfer_delay;
  logic [strobe_xfer_pkg::DATA_W-1:0] data_in;
  logic [4:0] group_size;
  strobe_xfer_pkg::ddr_word_t out_data, w[$], q[$];
  int mismatches = 0, checks_done = 0;
  strobe_xfer strobe_xfer_inst (.*);
  ddr_mem_model ddr_mem_model_inst (.*);
  always #5 clk = ~clk;
  initial #3 forever #40 edge_clock_one = ~edge_clock_one;
  initial #60000 stop_test(1);
  task automatic cmp(logic [31:0] got, exp);
    checks_done++;
    mismatches += int'(got !== exp);
    if (got !== exp)
      $display("Error %0t: %h not %h", $time, got, exp);
  endtask
  task automatic stop_test(int late);
    mismatches += late + q.size();
    $display("%0d checks, %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
    if (out_valid === 1'h1 && out_ready === 1'h1)
      cmp(out_data, q.size() ? q.pop_front() : 'x);
  initial
  begin
    void'($urandom(32'hAB8459C9));
    repeat (6) @(negedge clk);
    rst = 1'h0;
    // last read stalls the receiver, so its third word must be lost
    for (int i = 0; i < 7; i++)
    begin
      top_bottom = 1'($urandom);
      out_ready = 1'(i < 6);
      w = {};
      repeat (1 + (i + 2) % 3) w.push_back(32'($urandom));
      foreach (w[k]) if (k < 2 || i < 6) q.push_back(w[k]);
      ddr_mem_model_inst.burst(w, 3 + 3 * (i % 2));
      repeat (20) @(negedge clk);
      cmp(overflow, 1'(i == 6));
      cmp(group_size, top_bottom ? strobe_xfer_pkg::GROUP_TOPBOT
        : strobe_xfer_pkg::GROUP_SIDE);
      $display("read %0d done", i);
    end
    out_ready = 1'h1;
    repeat (4) @(negedge clk);
    stop_test(0);
  end
endmodule
